// File: verification/hcp_host_model.sv
// Host processor model: byte accesses on the command port bus
`timescale 1ns/1ps
module hcp_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] host_data_out_r,
  input  wire logic       host_data_oe_r,
  output logic            port_select,
  output logic            write_en,
  output logic            bus_strobe,
  output logic            low_addr_bit_zero,
  output logic            low_addr_bit_one,
  output logic [7:0]      host_data_in
);
  // ----------------------------------------
  // Idle bus at time zero
  // ----------------------------------------
  initial begin
    port_select = 1'b0;
    write_en = 1'b0;
    bus_strobe = 1'b0;
    low_addr_bit_zero = 1'b0;
    low_addr_bit_one = 1'b0;
    host_data_in = 8'h00;
  end

  // One byte access held for hold cycles; a word is two of these
  task automatic access(input logic w, input logic [1:0] i, input logic [7:0] d,
                        input int hold, output logic [7:0] q, output logic oe);
    @(posedge clk);
    port_select <= 1'b1;
    write_en <= w;
    low_addr_bit_zero <= i[0];
    low_addr_bit_one <= i[1];
    host_data_in <= d;
    bus_strobe <= 1'b1;
    repeat (hold) @(posedge clk);
    // Answer taken at the last edge of the held strobe
    q = host_data_out_r;
    oe = host_data_oe_r;
    // Released lines no longer show the last value
    port_select <= 1'b0;
    bus_strobe <= 1'b0;
    write_en <= ~w;
    low_addr_bit_zero <= ~i[0];
    low_addr_bit_one <= ~i[1];
    host_data_in <= ~d;
    // Gap long enough for the port's filter
    repeat (8) @(posedge clk);
  endtask
endmodule

// File: verification/hcp_port_tb.sv
// Self-checking bench for the host-to-sequencer command port
`timescale 1ns/1ps
module hcp_port_tb;
  localparam logic [15:0] FW = 16'h1B2D;  // Arbitrary version value
  logic                 clk, arst_n;      // Clock and reset
  logic                 sel, wr, stb;     // Host control pins
  logic                 a0, a1;           // Host address bits
  logic [7:0]           hdi, hdo, diag;   // Host data, diagnostic lines
  logic                 hoe, fin;         // Bus enable, op finished
  logic                 load, step, run;  // Smart clock outputs
  logic                 irq;              // Completion interrupt
  logic [15:0]          stat, saddr;      // Status in, address out
  logic [15:0]          last_addr;        // Address seen at last load
  hcp_pkg::hcp_cmd_type cmd;              // Command bits out
  int                   err_total = 0;
  int                   tests_run = 0;
  int                   load_cnt = 0;
  int                   step_cnt = 0;
  logic [7:0]           q;                // Last read byte
  logic                 oe;               // Enable seen at that read

  hcp_port #(.FW_VERSION(FW)) hcp_port_i (
    .clk(clk), .arst_n(arst_n), .port_select(sel), .write_en(wr), .bus_strobe(stb),
    .low_addr_bit_zero(a0), .low_addr_bit_one(a1), .host_data_in(hdi),
    .host_data_out_r(hdo), .host_data_oe_r(hoe), .diag_lines(diag), .op_finish(fin),
    .op_status(stat), .cmd_out(cmd), .seq_addr(saddr), .seq_load_r(load),
    .step_pulse_r(step), .running_r(run), .op_done_irq_r(irq));

  hcp_host_model hcp_host_model_i (
    .clk(clk), .host_data_out_r(hdo), .host_data_oe_r(hoe), .port_select(sel),
    .write_en(wr), .bus_strobe(stb), .low_addr_bit_zero(a0), .low_addr_bit_one(a1),
    .host_data_in(hdi));

  // ----------------------------------------
  // Clock and pulse counters
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count one-cycle pulses of the smart clock
  always @(posedge clk) begin
    if (step === 1'b1) step_cnt++;
    if (load === 1'b1) begin
      load_cnt++;
      last_addr = saddr;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // One host byte access, then settle past the edge
  task automatic acc(input logic w, input logic [1:0] i, input logic [7:0] d);
    hcp_host_model_i.access(w, i, d, 8, q, oe);
    #1;
  endtask

  // Bounded wait for the free-run level
  task automatic wait_run(input logic lvl);
    int n;
    n = 0;
    while (run !== lvl && n < 40) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (run !== lvl) begin
      err_total++;
      $display("wrong value at %0t: run level timeout", $time);
      finish_test();
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check(8'(cmd) === 8'h00 && saddr === 16'h0000, "cmd or addr after reset");
    check({irq, run, load, step, hoe} === 5'h00, "flags after reset");
    acc(1'b0, 2'h2, 8'h00);
    check(q === FW[15:8] && oe === 1'b1, "version high byte");
    acc(1'b0, 2'h3, 8'h00);
    check(q === FW[7:0], "version low byte");
    $display("test reset done");
  endtask

  // Plain bits 0 to 4 each alone, then hold across other writes
  task automatic t_bits;
    for (int b = 0; b < 5; b++) begin
      acc(1'b1, 2'h1, 8'h01 << b);
      check(8'(cmd) === (8'h01 << b) && oe === 1'b0, "plain command bit");
    end
    acc(1'b1, 2'h2, 8'h12);
    acc(1'b1, 2'h3, 8'h34);
    acc(1'b1, 2'h0, 8'hFF);
    check(8'(cmd) === 8'h10 && saddr === 16'h1234, "bits held, word bytes");
    acc(1'b0, 2'h0, 8'h00);
    check(oe === 1'b0, "unmapped read drove bus");
    $display("test bits done");
  endtask

  task automatic t_diag;
    @(posedge clk);
    diag <= 8'hA5;
    acc(1'b0, 2'h1, 8'h00);
    check(q === 8'hA5 && oe === 1'b1, "diagnostic read");
    $display("test diag done");
  endtask

  // Request alone: one pass, no load, no run
  task automatic t_step;
    int s;
    int l;
    s = step_cnt;
    l = load_cnt;
    acc(1'b1, 2'h1, 8'h20);
    repeat (4) @(posedge clk);
    #1;
    check(step_cnt == s + 1 && load_cnt == l, "single step pass");
    check(cmd.request === 1'b0 && run === 1'b0, "request left or ran");
    $display("test step done");
  endtask

  task automatic t_launch;
    int l;
    l = load_cnt;
    acc(1'b1, 2'h2, 8'hC3);
    acc(1'b1, 2'h3, 8'h5A);
    fork
      acc(1'b1, 2'h1, 8'hE0);
      begin
        repeat (7) @(posedge clk);
        #1;
        check(cmd.request === 1'b1 && cmd.forced_jump === 1'b0, "request before jump");
      end
    join
    wait_run(1'b1);
    check(load_cnt == l + 1 && last_addr === 16'hC35A, "forced jump load");
    check(cmd.request === 1'b0 && cmd.forced_jump === 1'b0, "latches not cleared");
    check(irq === 1'b0, "interrupt while running");
    $display("test launch done");
  endtask

  task automatic t_done;
    @(posedge clk);
    stat <= 16'h00C3;
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check(irq === 1'b1 && run === 1'b0, "completion interrupt");
    acc(1'b0, 2'h2, 8'h00);
    check(q === 8'h00 && irq === 1'b0, "status high or irq kept");
    acc(1'b0, 2'h3, 8'h00);
    check(q === 8'hC3, "status low");
    @(posedge clk);
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(irq === 1'b0, "finish while idle");
    $display("test done irq done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    diag = 8'h00;
    fin = 1'b0;
    stat = 16'h0000;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    t_reset();
    t_bits();
    t_diag();
    t_step();
    t_launch();
    t_done();
    finish_test();
  end
endmodule

// File: verilog/hcp_defines.svh
// Constants for the host-to-sequencer command port
`ifndef HCP_DEFINES_SVH
`define HCP_DEFINES_SVH

// ------------------------------------------------------------
// Host addresses and low-bit register indices
// ------------------------------------------------------------
`define HCP_HOST_ADDR_COMMAND 16'h3405
`define HCP_HOST_ADDR_PARAM   16'h3406
`define HCP_IDX_COMMAND       2'h1
`define HCP_IDX_PARAM_HI      2'h2
`define HCP_IDX_PARAM_LO      2'h3

// ------------------------------------------------------------
// Command bit positions
// ------------------------------------------------------------
`define HCP_BIT_LONG_SWEEP    0
`define HCP_BIT_REQUEST       5
`define HCP_BIT_RUN           6
`define HCP_BIT_FORCED_JUMP   7

// ------------------------------------------------------------
// Reset values and status codes
// ------------------------------------------------------------
`define HCP_RST_BYTE          8'h00
`define HCP_RST_WORD          16'h0000
`define HCP_STATUS_OK         16'h0000
`define HCP_FW_VERSION        16'h0A5C

`endif

// File: verilog/hcp_pkg.sv
// Types shared by the host-to-sequencer command port
package hcp_pkg;

  // Command byte, bit 7 down to bit 0
  typedef struct packed {
    logic forced_jump;
    logic run;
    logic request;
    logic skip_gate_wait;
    logic clear_output_fsm;
    logic spare_flag_two;
    logic spare_flag_one;
    logic long_sweep;
  } hcp_cmd_type;

  // Host bus pins as seen by the port
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       stb;
    logic [1:0] addr;
    logic [7:0] data;
  } hcp_bus_type;

  // Smart clock loop states
  typedef enum logic [1:0] {
    ST_STEP_LOOP,
    ST_STEP_PASS,
    ST_RUN_LOOP
  } hcp_clk_state_type;

endpackage

// File: verilog/hcp_port.sv
// Host-to-sequencer command port: host bus slave, command latches, status
`timescale 1ns/1ps
`include "hcp_defines.svh"
module hcp_port #(
  parameter logic [15:0] FW_VERSION = `HCP_FW_VERSION  // Arbitrary version value
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               port_select,
  input  wire logic               write_en,
  input  wire logic               bus_strobe,
  input  wire logic               low_addr_bit_zero,
  input  wire logic               low_addr_bit_one,
  input  wire logic [7:0]         host_data_in,
  output logic [7:0]              host_data_out_r,
  output logic                    host_data_oe_r,
  input  wire logic [7:0]         diag_lines,
  input  wire logic               op_finish,
  input  wire logic [15:0]        op_status,
  output hcp_pkg::hcp_cmd_type    cmd_out,
  output logic [15:0]             seq_addr,
  output logic                    seq_load_r,
  output logic                    step_pulse_r,
  output logic                    running_r,
  output logic                    op_done_irq_r
);

  // ----------------------------------------------------------
  // Pin synchronisers: three flops, change taken when 2 and 3 agree
  // ----------------------------------------------------------
  hcp_pkg::hcp_bus_type pin_in;   // Raw pins
  hcp_pkg::hcp_bus_type sync1_r;  // First stage
  hcp_pkg::hcp_bus_type sync2_r;  // Second stage
  hcp_pkg::hcp_bus_type sync3_r;  // Third stage
  hcp_pkg::hcp_bus_type bus_r;    // Filtered pins

  assign pin_in = '{sel: port_select, wr: write_en, stb: bus_strobe,
                    addr: {low_addr_bit_one, low_addr_bit_zero}, data: host_data_in};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Per-bit agreement filter: a bit moves only when stages 2 and 3 agree
  wire logic [$bits(hcp_pkg::hcp_bus_type)-1:0] filt_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < $bits(hcp_pkg::hcp_bus_type); gi++) begin : g_filt
      assign filt_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : bus_r[gi];
    end
  endgenerate

  // Filtered pin register, one process for the whole bus
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_r <= '0;
    end else begin
      bus_r <= filt_nxt;
    end
  end

  // ----------------------------------------------------------
  // Address decode and access edges
  // ----------------------------------------------------------
  logic       access;        // Port selected with strobe
  logic       access_d_r;    // Access one cycle ago
  logic       access_start;  // First cycle of an access
  logic       mapped;        // Address hits a register
  logic       cmd_wr;        // Command write strobe active
  logic       cmd_wr_d_r;    // Command write strobe one cycle ago
  logic       cmd_start;     // Command strobe rising edge
  logic       cmd_end;       // Command strobe falling edge
  logic [7:0] cmd_hold_r;    // Command byte caught at strobe start

  assign access       = bus_r.sel && bus_r.stb;
  assign access_start = access && !access_d_r;
  assign mapped       = (bus_r.addr == `HCP_IDX_COMMAND) || (bus_r.addr == `HCP_IDX_PARAM_HI) ||
                        (bus_r.addr == `HCP_IDX_PARAM_LO);
  assign cmd_wr       = access && bus_r.wr && (bus_r.addr == `HCP_IDX_COMMAND);
  assign cmd_start    = cmd_wr && !cmd_wr_d_r;
  assign cmd_end      = !cmd_wr && cmd_wr_d_r;

  // Edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      access_d_r <= 1'b0;
      cmd_wr_d_r <= 1'b0;
    end else begin
      access_d_r <= access;
      cmd_wr_d_r <= cmd_wr;
    end
  end

  // Command byte held for the end of the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_hold_r <= `HCP_RST_BYTE;
    end else if (cmd_start) begin
      cmd_hold_r <= bus_r.data;
    end
  end

  // ----------------------------------------------------------
  // Command latches
  // ----------------------------------------------------------
  hcp_pkg::hcp_cmd_type cmd_r;     // Plain command bits
  logic                 request_r; // Separate request flop
  logic                 jump_r;    // Separate forced jump flop
  logic                 clear_latches;
  logic                 cmd_busy;  // Command write still settling

  assign clear_latches = step_pulse_r;
  // Busy also in the strobe-end cycle, so the jump bit is latched before the pass
  assign cmd_busy      = cmd_wr || cmd_wr_d_r;

  // Plain bits update on the strobe end and hold otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r <= `HCP_RST_BYTE;
    end else if (cmd_end) begin
      cmd_r <= cmd_hold_r;
    end
  end

  // Request taken at strobe start; a new set beats the slave clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      request_r <= 1'b0;
    end else if (cmd_start && bus_r.data[`HCP_BIT_REQUEST]) begin
      request_r <= 1'b1;
    end else if (clear_latches) begin
      request_r <= 1'b0;
    end
  end

  // Forced jump taken at strobe end; set beats clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      jump_r <= 1'b0;
    end else if (cmd_end && cmd_hold_r[`HCP_BIT_FORCED_JUMP]) begin
      jump_r <= 1'b1;
    end else if (clear_latches) begin
      jump_r <= 1'b0;
    end
  end

  // Command bits toward the controller
  always_comb begin
    cmd_out             = cmd_r;
    cmd_out.request     = request_r;
    cmd_out.forced_jump = jump_r;
  end

  // ----------------------------------------------------------
  // Address/parameter word, written a byte at a time
  // ----------------------------------------------------------
  logic [15:0] param_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      param_r <= `HCP_RST_WORD;
    end else if (access_start && bus_r.wr && bus_r.addr == `HCP_IDX_PARAM_HI) begin
      param_r[15:8] <= bus_r.data;
    end else if (access_start && bus_r.wr && bus_r.addr == `HCP_IDX_PARAM_LO) begin
      param_r[7:0] <= bus_r.data;
    end
  end

  assign seq_addr = param_r;

  // ----------------------------------------------------------
  // Smart clock
  // ----------------------------------------------------------
  hcp_smart_clock u_clk (
    .clk          (clk),
    .arst_n       (arst_n),
    .request_set  (request_r),
    .jump_set     (jump_r),
    .run_set      (cmd_r.run),
    .write_busy   (cmd_busy),
    .op_finish    (op_finish),
    .step_pulse_r (step_pulse_r),
    .seq_load_r   (seq_load_r),
    .running_r    (running_r)
  );

  // ----------------------------------------------------------
  // Status word and completion interrupt
  // ----------------------------------------------------------
  logic [15:0] status_r;
  logic        finish_ok;

  assign finish_ok = op_finish && running_r;

  // Version at power-up, result code at completion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= FW_VERSION;
    end else if (finish_ok) begin
      status_r <= op_status;
    end
  end

  // Raised on completion, held until the host touches the port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_done_irq_r <= 1'b0;
    end else if (finish_ok) begin
      op_done_irq_r <= 1'b1;
    end else if (access_start) begin
      op_done_irq_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Read path
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_data_out_r <= `HCP_RST_BYTE;
      host_data_oe_r  <= 1'b0;
    end else begin
      host_data_oe_r <= access && !bus_r.wr && mapped;
      case (bus_r.addr)
        `HCP_IDX_COMMAND:  host_data_out_r <= diag_lines;
        `HCP_IDX_PARAM_HI: host_data_out_r <= status_r[15:8];
        `HCP_IDX_PARAM_LO: host_data_out_r <= status_r[7:0];
        default:           host_data_out_r <= `HCP_RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence pass_with_run;
    step_pulse_r && cmd_r.run ##1 running_r;
  endsequence

  sequence pass_then_clear;
    step_pulse_r && !cmd_start ##1 !request_r && !jump_r;
  endsequence

  request_capture_a: assert property (cmd_start && bus_r.data[`HCP_BIT_REQUEST] |=> request_r)
    else $error("request not caught at strobe start");
  jump_capture_a: assert property (cmd_end && cmd_hold_r[`HCP_BIT_FORCED_JUMP] |=> jump_r)
    else $error("forced jump not caught at strobe end");
  jump_late_a: assert property (cmd_start && !jump_r |=> !jump_r)
    else $error("forced jump set at strobe start");
  step_clear_a: assert property (step_pulse_r && !cmd_start |-> pass_then_clear)
    else $error("latches not cleared after step pass");
  run_enter_a: assert property (step_pulse_r && cmd_r.run |-> pass_with_run)
    else $error("run loop not entered");
  load_jump_a: assert property (step_pulse_r |-> seq_load_r == $past(jump_r))
    else $error("sequencer load does not follow forced jump");
  irq_raise_a: assert property (finish_ok |=> op_done_irq_r && status_r == $past(op_status))
    else $error("completion not reported");
  irq_norun_a: assert property (op_done_irq_r && !$past(access_start) |-> !running_r)
    else $error("interrupt raised while running");
  irq_hold_a: assert property (op_done_irq_r && !access_start |=> op_done_irq_r)
    else $error("interrupt dropped without host access");
  cmd_hold_a: assert property (!cmd_end |=> $stable(cmd_r))
    else $error("command bits changed without a write");
  diag_read_a: assert property (access && !bus_r.wr && bus_r.addr == `HCP_IDX_COMMAND
                                |=> host_data_oe_r && host_data_out_r == $past(diag_lines))
    else $error("diagnostic byte not returned");

endmodule

// File: verilog/hcp_smart_clock.sv
// Smart clock: single-step loop, step pass and free-running loop
`timescale 1ns/1ps
module hcp_smart_clock (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic request_set,
  input  wire logic jump_set,
  input  wire logic run_set,
  input  wire logic write_busy,
  input  wire logic op_finish,
  output logic      step_pulse_r,
  output logic      seq_load_r,
  output logic      running_r
);

  hcp_pkg::hcp_clk_state_type state_r;  // Current loop
  hcp_pkg::hcp_clk_state_type state_nxt; // Next loop

  // ----------------------------------------------------------
  // Next-state choice
  // ----------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Wait for a request once the command write has ended
      hcp_pkg::ST_STEP_LOOP: begin
        if (request_set && !write_busy) begin
          state_nxt = hcp_pkg::ST_STEP_PASS;
        end
      end
      // One pass, then back to stepping or on to running
      hcp_pkg::ST_STEP_PASS: begin
        state_nxt = run_set ? hcp_pkg::ST_RUN_LOOP : hcp_pkg::ST_STEP_LOOP;
      end
      // A fresh request starts another step pass; finish drops back into the step loop
      hcp_pkg::ST_RUN_LOOP: begin
        if (request_set && !write_busy) begin
          state_nxt = hcp_pkg::ST_STEP_PASS;
        end else if (op_finish) begin
          state_nxt = hcp_pkg::ST_STEP_LOOP;
        end
      end
      default: begin
        state_nxt = hcp_pkg::ST_STEP_LOOP;
      end
    endcase
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= hcp_pkg::ST_STEP_LOOP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------
  // Registered outputs, one cycle wide pass strobes
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_pulse_r <= 1'b0;
      seq_load_r   <= 1'b0;
      running_r    <= 1'b0;
    end else begin
      step_pulse_r <= (state_nxt == hcp_pkg::ST_STEP_PASS);
      seq_load_r   <= (state_nxt == hcp_pkg::ST_STEP_PASS) && jump_set;
      running_r    <= (state_nxt == hcp_pkg::ST_RUN_LOOP);
    end
  end

endmodule
